// file: pkg/fault_status_pkg.sv
/*
 * Shared constants for the fault status register bank: command codes, bit positions and reset values.
 * Assumes a single clock domain and a command decoder outside the bank that presents command codes.
 */
package fault_status_pkg;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
	localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
	localparam logic [7:0] CMD_TEMPERATURE_STATUS = 8'h7D;
	localparam logic [7:0] CMD_COMM_LOGIC_STATUS = 8'h7E;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Bits that carry a function in each status byte.
	localparam logic [7:0] OUTPUT_CURRENT_USED = 8'hFC;
	localparam logic [7:0] INPUT_USED = 8'hF0;
	localparam logic [7:0] TEMPERATURE_USED = 8'hFE;
	localparam logic [7:0] COMM_LOGIC_USED = 8'hE2;
	// Output current status bit positions.
	localparam int OC_FAULT_BIT = 7;
	localparam int OC_LV_FAULT_BIT = 6;
	localparam int OC_WARNING_BIT = 5;
	localparam int UC_FAULT_BIT = 4;
	localparam int PHASE_A_FAULT_BIT = 3;
	localparam int PHASE_B_FAULT_BIT = 2;
	// Input status bit positions.
	localparam int IN_OV_FAULT_BIT = 7;
	localparam int IN_OV_WARNING_BIT = 6;
	localparam int IN_UV_WARNING_BIT = 5;
	localparam int IN_UV_FAULT_BIT = 4;
	// Temperature status bit positions.
	localparam int OVER_TEMPERATURE_FAULT_BIT = 7;
	localparam int OVER_TEMPERATURE_WARNING_BIT = 6;
	localparam int UNDER_TEMPERATURE_WARNING_BIT = 5;
	localparam int UNDER_TEMPERATURE_FAULT_BIT = 4;
	localparam int ONCHIP_SOURCE_BIT = 3;
	localparam int EXT_A_SOURCE_BIT = 2;
	localparam int EXT_B_SOURCE_BIT = 1;
	// Communication and logic status bit positions.
	localparam int BAD_COMMAND_BIT = 7;
	localparam int BAD_DATA_BIT = 6;
	localparam int PACKET_ERROR_BIT = 5;
	localparam int OTHER_COMM_BIT = 1;
	// Summary word bit positions.
	localparam int SUMMARY_OUTPUT_CURRENT_BIT = 14;
	localparam int SUMMARY_INPUT_BIT = 13;
endpackage

// file: pkg/status_byte_if.sv
/*
 * Carrier between the bank and one sticky status byte: set events, clear and the held value.
 * Assumes both ends run on the same clock.
 */
interface status_byte_if;
	logic [7:0] set_bits;
	logic clear;
	logic [7:0] value;
	modport owner (output set_bits, output clear, input value);
	modport holder (input set_bits, input clear, output value);
endinterface

// file: hw/sticky_byte.sv
/*
 * One sticky status byte: bits set by events, held until cleared, unused bits forced to zero.
 * Assumes set and clear come from logic on the same clock.
 */
module sticky_byte #(
	parameter logic [7:0] USED_MASK = 8'hFF
) (
	input wire logic clk,
	input wire logic rst_n,
	status_byte_if.holder port
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb begin
		value_nxt = port.clear ? port.set_bits : (value_r | port.set_bits);
		value_nxt = value_nxt & USED_MASK;
	end

	// Holds the byte; reset brings it to zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			value_r <= fault_status_pkg::STATUS_RESET;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign port.value = value_r;
endmodule

// file: hw/fault_status_bytes.sv
/*
 * Four read-only fault status bytes with summary bits, read by command code.
 * Assumes fault detectors and the bus command decoder are on CLOCK and give one-cycle event pulses.
 */
module fault_status_bytes (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Output current events.
	input wire logic OUTPUT_OVERCURRENT_FAULT,
	input wire logic OVERCURRENT_LOW_VOLTAGE_FAULT,
	input wire logic OUTPUT_OVERCURRENT_WARNING,
	input wire logic OUTPUT_UNDERCURRENT_FAULT,
	input wire logic PHASE_A_FAULT,
	input wire logic PHASE_B_FAULT,
	// Input voltage events.
	input wire logic INPUT_OVERVOLTAGE_FAULT,
	input wire logic INPUT_OVERVOLTAGE_WARNING,
	input wire logic INPUT_UNDERVOLTAGE_WARNING,
	input wire logic INPUT_UNDERVOLTAGE_FAULT,
	// Temperature events and their sensor.
	input wire logic OVER_TEMPERATURE_FAULT,
	input wire logic OVER_TEMPERATURE_WARNING,
	input wire logic UNDER_TEMPERATURE_WARNING,
	input wire logic UNDER_TEMPERATURE_FAULT,
	input wire logic ONCHIP_SENSOR_SOURCE,
	input wire logic EXTERNAL_SENSOR_A_SOURCE,
	input wire logic EXTERNAL_SENSOR_B_SOURCE,
	// Communication events from the command decoder.
	input wire logic BAD_COMMAND,
	input wire logic BAD_DATA,
	input wire logic PACKET_ERROR,
	input wire logic OTHER_COMM_FAULT,
	// Command port: code, read and write strobes, fault clear.
	input wire logic [7:0] CMD_CODE,
	input wire logic CMD_READ,
	input wire logic CMD_WRITE,
	input wire logic CLEAR_FAULTS,
	// Read answer.
	output logic [7:0] READ_DATA,
	output logic READ_VALID,
	output logic CMD_HIT,
	// Summary word bits.
	output logic OUTPUT_CURRENT_SUMMARY_BIT,
	output logic INPUT_SUMMARY_BIT
);
	status_byte_if cur_if ();
	status_byte_if in_if ();
	status_byte_if tmp_if ();
	status_byte_if cml_if ();
	logic is_status_cmd;
	logic ro_write;
	logic [7:0] read_data_r;
	logic read_valid_r;

	// Tells whether a code names one of the four status bytes.
	function automatic logic status_code(input logic [7:0] code);
		status_code = (code == fault_status_pkg::CMD_OUTPUT_CURRENT_STATUS) ||
			(code == fault_status_pkg::CMD_INPUT_STATUS) ||
			(code == fault_status_pkg::CMD_TEMPERATURE_STATUS) ||
			(code == fault_status_pkg::CMD_COMM_LOGIC_STATUS);
	endfunction

	assign is_status_cmd = status_code(CMD_CODE);
	// A write aimed at a status byte does not load it and is reported as a read-only write.
	assign ro_write = CMD_WRITE && is_status_cmd;
	assign CMD_HIT = is_status_cmd;

	// Output current set events.
	always_comb begin
		cur_if.set_bits = 8'h00;
		cur_if.set_bits[fault_status_pkg::OC_FAULT_BIT] = OUTPUT_OVERCURRENT_FAULT;
		cur_if.set_bits[fault_status_pkg::OC_LV_FAULT_BIT] = OVERCURRENT_LOW_VOLTAGE_FAULT;
		cur_if.set_bits[fault_status_pkg::OC_WARNING_BIT] = OUTPUT_OVERCURRENT_WARNING;
		cur_if.set_bits[fault_status_pkg::UC_FAULT_BIT] = OUTPUT_UNDERCURRENT_FAULT;
		cur_if.set_bits[fault_status_pkg::PHASE_A_FAULT_BIT] = PHASE_A_FAULT;
		cur_if.set_bits[fault_status_pkg::PHASE_B_FAULT_BIT] = PHASE_B_FAULT;
	end

	// Input voltage set events.
	always_comb begin
		in_if.set_bits = 8'h00;
		in_if.set_bits[fault_status_pkg::IN_OV_FAULT_BIT] = INPUT_OVERVOLTAGE_FAULT;
		in_if.set_bits[fault_status_pkg::IN_OV_WARNING_BIT] = INPUT_OVERVOLTAGE_WARNING;
		in_if.set_bits[fault_status_pkg::IN_UV_WARNING_BIT] = INPUT_UNDERVOLTAGE_WARNING;
		in_if.set_bits[fault_status_pkg::IN_UV_FAULT_BIT] = INPUT_UNDERVOLTAGE_FAULT;
	end

	// Temperature set events; a source bit is only taken alongside a temperature event.
	always_comb begin
		logic any_temp;
		any_temp = OVER_TEMPERATURE_FAULT || OVER_TEMPERATURE_WARNING ||
			UNDER_TEMPERATURE_WARNING || UNDER_TEMPERATURE_FAULT;
		tmp_if.set_bits = 8'h00;
		tmp_if.set_bits[fault_status_pkg::OVER_TEMPERATURE_FAULT_BIT] = OVER_TEMPERATURE_FAULT;
		tmp_if.set_bits[fault_status_pkg::OVER_TEMPERATURE_WARNING_BIT] = OVER_TEMPERATURE_WARNING;
		tmp_if.set_bits[fault_status_pkg::UNDER_TEMPERATURE_WARNING_BIT] = UNDER_TEMPERATURE_WARNING;
		tmp_if.set_bits[fault_status_pkg::UNDER_TEMPERATURE_FAULT_BIT] = UNDER_TEMPERATURE_FAULT;
		tmp_if.set_bits[fault_status_pkg::ONCHIP_SOURCE_BIT] = any_temp && ONCHIP_SENSOR_SOURCE;
		tmp_if.set_bits[fault_status_pkg::EXT_A_SOURCE_BIT] = any_temp && EXTERNAL_SENSOR_A_SOURCE;
		tmp_if.set_bits[fault_status_pkg::EXT_B_SOURCE_BIT] = any_temp && EXTERNAL_SENSOR_B_SOURCE;
	end

	// Communication set events, including writes aimed at these read-only bytes.
	always_comb begin
		cml_if.set_bits = 8'h00;
		cml_if.set_bits[fault_status_pkg::BAD_COMMAND_BIT] = BAD_COMMAND;
		cml_if.set_bits[fault_status_pkg::BAD_DATA_BIT] = BAD_DATA;
		cml_if.set_bits[fault_status_pkg::PACKET_ERROR_BIT] = PACKET_ERROR;
		cml_if.set_bits[fault_status_pkg::OTHER_COMM_BIT] = OTHER_COMM_FAULT || ro_write;
	end

	// Fault clear reaches every byte at once.
	assign cur_if.clear = CLEAR_FAULTS;
	assign in_if.clear = CLEAR_FAULTS;
	assign tmp_if.clear = CLEAR_FAULTS;
	assign cml_if.clear = CLEAR_FAULTS;

	sticky_byte #(.USED_MASK(fault_status_pkg::OUTPUT_CURRENT_USED)) u_cur (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.port(cur_if)
	);
	sticky_byte #(.USED_MASK(fault_status_pkg::INPUT_USED)) u_in (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.port(in_if)
	);
	sticky_byte #(.USED_MASK(fault_status_pkg::TEMPERATURE_USED)) u_tmp (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.port(tmp_if)
	);
	sticky_byte #(.USED_MASK(fault_status_pkg::COMM_LOGIC_USED)) u_cml (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.port(cml_if)
	);

	// Read answer: one byte a cycle after a read of a status code; others answer zero with no valid.
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			read_data_r <= fault_status_pkg::STATUS_RESET;
			read_valid_r <= 1'b0;
		end else begin
			read_valid_r <= CMD_READ && is_status_cmd;
			if (!CMD_READ) begin
				read_data_r <= read_data_r;
			end else if (CMD_CODE == fault_status_pkg::CMD_OUTPUT_CURRENT_STATUS) begin
				read_data_r <= cur_if.value;
			end else if (CMD_CODE == fault_status_pkg::CMD_INPUT_STATUS) begin
				read_data_r <= in_if.value;
			end else if (CMD_CODE == fault_status_pkg::CMD_TEMPERATURE_STATUS) begin
				read_data_r <= tmp_if.value;
			end else if (CMD_CODE == fault_status_pkg::CMD_COMM_LOGIC_STATUS) begin
				read_data_r <= cml_if.value;
			end else begin
				read_data_r <= fault_status_pkg::STATUS_RESET;
			end
		end
	end

	assign READ_DATA = read_data_r;
	assign READ_VALID = read_valid_r;

	// Summary bits follow the held bytes.
	assign OUTPUT_CURRENT_SUMMARY_BIT = |cur_if.value;
	assign INPUT_SUMMARY_BIT = |in_if.value;
endmodule

// file: testbench/fault_status_bytes_properties.sv
/* Port checker for the fault status bank.
   Assumes one clock and a synchronous active-low reset. */
module fault_status_bytes_properties (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Events watched.
	input wire logic OUTPUT_OVERCURRENT_FAULT,
	input wire logic INPUT_OVERVOLTAGE_FAULT,
	// Command port and answer.
	input wire logic [7:0] CMD_CODE,
	input wire logic CMD_READ,
	input wire logic CLEAR_FAULTS,
	input wire logic [7:0] READ_DATA,
	input wire logic READ_VALID,
	input wire logic CMD_HIT,
	input wire logic OUTPUT_CURRENT_SUMMARY_BIT,
	input wire logic INPUT_SUMMARY_BIT
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	// A read strobe aimed at one of the four status codes.
	sequence status_read;
		CMD_READ && CMD_HIT;
	endsequence
	a_hit_decode: assert property (CMD_HIT == (CMD_CODE >= 8'h7b && CMD_CODE <= 8'h7e))
		else $error("bad hit");
	a_read_answered: assert property (status_read |=> READ_VALID) else $error("read unanswered");
	a_no_false_valid: assert property (!(CMD_READ && CMD_HIT) |=> !READ_VALID) else $error("stray valid");
	a_data_holds: assert property (!CMD_READ |=> $stable(READ_DATA)) else $error("data moved");
	a_input_low_zero: assert property (READ_VALID && $past(CMD_CODE) == 8'h7c |-> READ_DATA[3:0] == 4'h0)
		else $error("unused input bits set");
	a_current_summary: assert property (OUTPUT_OVERCURRENT_FAULT |=> OUTPUT_CURRENT_SUMMARY_BIT)
		else $error("current summary low");
	a_input_summary: assert property (INPUT_OVERVOLTAGE_FAULT |=> INPUT_SUMMARY_BIT)
		else $error("input summary low");
	a_current_sticky: assert property ($fell(OUTPUT_CURRENT_SUMMARY_BIT) |-> $past(CLEAR_FAULTS))
		else $error("current bits lost");
	a_input_sticky: assert property ($fell(INPUT_SUMMARY_BIT) |-> $past(CLEAR_FAULTS))
		else $error("input bits lost");
endmodule
bind fault_status_bytes fault_status_bytes_properties chk (.CLOCK, .RESET_N, .OUTPUT_OVERCURRENT_FAULT,
	.INPUT_OVERVOLTAGE_FAULT, .CMD_CODE, .CMD_READ, .CLEAR_FAULTS, .READ_DATA, .READ_VALID, .CMD_HIT,
	.OUTPUT_CURRENT_SUMMARY_BIT, .INPUT_SUMMARY_BIT);

// file: testbench/pmbus_host_model.sv
/* Behavioural host that issues status commands.
   Assumes the bank answers one cycle after the strobe edge. */
module pmbus_host_model (
	// Clock and answer.
	input wire logic clk,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	// Command port.
	output logic [7:0] code,
	output logic rd,
	output logic wr,
	output logic clr
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bus idle at time zero.
	initial begin
		code = 8'h00;
		{rd, wr, clr} = 3'h0;
	end
	// One strobe for one cycle; a cycle later the code is turned over, then one byte taken.
	task automatic issue(input logic [7:0] c, input logic [2:0] kind, output logic [7:0] d, output logic v);
		@(negedge clk);
		code = c;
		{rd, wr, clr} = kind;
		@(negedge clk);
		{rd, wr, clr} = 3'h0;
		code = ~c;
		d = rd_data;
		v = rd_valid;
	endtask
endmodule

// file: testbench/fault_status_bytes_tb.sv
/* Self-checking bench for the fault status bank.
   Assumes the host model and the events change at the falling edge. */
module fault_status_bytes_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [20:0] ev = '0;
	logic [7:0] code, rdata, dd;
	logic rd, wr, clr, rvalid, dv;
	logic sum_cur, sum_in;
	int mismatches = 0;
	int num_checks = 0;
	// Byte and bit position that each event input sets.
	int rg[21] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
	int bn[21] = '{7, 6, 5, 4, 3, 2, 7, 6, 5, 4, 7, 6, 5, 4, 3, 2, 1, 7, 6, 5, 1};
	// Clock of 8 ns.
	always #4 clock = ~clock;
	fault_status_bytes dut (.CLOCK(clock), .RESET_N(reset_n), .OUTPUT_OVERCURRENT_FAULT(ev[0]),
		.OVERCURRENT_LOW_VOLTAGE_FAULT(ev[1]), .OUTPUT_OVERCURRENT_WARNING(ev[2]), .OUTPUT_UNDERCURRENT_FAULT(ev[3]),
		.PHASE_A_FAULT(ev[4]), .PHASE_B_FAULT(ev[5]), .INPUT_OVERVOLTAGE_FAULT(ev[6]), .INPUT_OVERVOLTAGE_WARNING(ev[7]),
		.INPUT_UNDERVOLTAGE_WARNING(ev[8]), .INPUT_UNDERVOLTAGE_FAULT(ev[9]), .OVER_TEMPERATURE_FAULT(ev[10]),
		.OVER_TEMPERATURE_WARNING(ev[11]), .UNDER_TEMPERATURE_WARNING(ev[12]), .UNDER_TEMPERATURE_FAULT(ev[13]),
		.ONCHIP_SENSOR_SOURCE(ev[14]), .EXTERNAL_SENSOR_A_SOURCE(ev[15]), .EXTERNAL_SENSOR_B_SOURCE(ev[16]),
		.BAD_COMMAND(ev[17]), .BAD_DATA(ev[18]), .PACKET_ERROR(ev[19]), .OTHER_COMM_FAULT(ev[20]),
		.CMD_CODE(code), .CMD_READ(rd), .CMD_WRITE(wr), .CLEAR_FAULTS(clr), .READ_DATA(rdata), .READ_VALID(rvalid),
		.CMD_HIT(), .OUTPUT_CURRENT_SUMMARY_BIT(sum_cur), .INPUT_SUMMARY_BIT(sum_in));
	pmbus_host_model host (.clk(clock), .rd_data(rdata), .rd_valid(rvalid), .code(code), .rd(rd), .wr(wr), .clr(clr));
	// Reads one code and compares the answer flag and byte.
	task automatic read_expect(input logic [7:0] c, input logic [7:0] exp, input logic vexp);
		host.issue(c, 3'h4, dd, dv);
		num_checks++;
		if ({dv, dd} !== {vexp, exp}) begin
			$display("wrong value at %0t: code %h gave %b %h", $time, c, dv, dd);
			mismatches++;
		end
	endtask
	// Compares one level output against its expected value.
	task automatic flag_expect(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s is %b", $time, what, got);
			mismatches++;
		end
	endtask
	// Raises a set of events for one cycle.
	task automatic pulse(input logic [20:0] m);
		@(negedge clock);
		ev = m;
		@(negedge clock);
		ev = '0;
	endtask
	// Codes 7A to 7F after reset: status bytes zero, neighbours unanswered.
	task automatic after_reset();
		for (int r = 0; r < 6; r++) read_expect(8'h7a + 8'(r), 8'h00, 1'(r > 0 && r < 5));
	endtask
	// Each event alone, or a source bit with an over-temperature fault, sets its bit, which outlives the event until a clear.
	task automatic each_event();
		logic [20:0] m;
		logic [7:0] e;
		for (int i = 0; i < 21; i++) begin
			m = 21'h0_0001 << i;
			e = 8'h01 << bn[i];
			if (rg[i] == 2 && bn[i] < 4) begin
				m[10] = 1'b1;
				e[7] = 1'b1;
			end
			pulse(m);
			flag_expect(sum_cur, 1'(rg[i] == 0), "current summary");
			flag_expect(sum_in, 1'(rg[i] == 1), "input summary");
			read_expect(8'h7b + 8'(rg[i]), e, 1'b1);
			host.issue(8'h00, 3'h1, dd, dv);
			read_expect(8'h7b + 8'(rg[i]), 8'h00, 1'b1);
		end
	endtask
	// All events at once: unused positions stay zero.
	task automatic all_events();
		pulse('1);
		read_expect(8'h7b, 8'hfc, 1'b1);
		read_expect(8'h7c, 8'hf0, 1'b1);
		read_expect(8'h7d, 8'hfe, 1'b1);
		read_expect(8'h7e, 8'he2, 1'b1);
		host.issue(8'h00, 3'h1, dd, dv);
		flag_expect(sum_cur, 1'b0, "current summary");
		flag_expect(sum_in, 1'b0, "input summary");
	endtask
	// A reset in mid-run clears every held bit and both summaries.
	task automatic reset_midrun();
		pulse('1);
		@(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		flag_expect(sum_cur, 1'b0, "current summary");
		flag_expect(sum_in, 1'b0, "input summary");
		for (int r = 0; r < 4; r++) read_expect(8'h7b + 8'(r), 8'h00, 1'b1);
	endtask
	// A write to a status byte leaves it alone and flags the refused write.
	task automatic write_refused();
		pulse(21'h0_0001);
		host.issue(8'h7b, 3'h2, dd, dv);
		read_expect(8'h7b, 8'h80, 1'b1);
		read_expect(8'h7e, 8'h02, 1'b1);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Reset for 12 cycles, then the scenarios in turn.
	initial begin
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		after_reset();
		each_event();
		all_events();
		write_refused();
		reset_midrun();
		tally_and_finish();
	end
endmodule
